// >>> verilog/dpmu_top.sv
// Register bank and lookup for DiffServ codes 0x10 to 0x3F
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// - One 2-bit entry per code 0x10..0x3F, four per byte, low code low.
// - Every entry is software read/write and resets to zero.
// - Offset 0x97 holds codes 0x1C..0x1F; 0x1F in bits 7-6.
// - Offset 0x98 holds codes 0x20..0x23; 0x20 in bits 1-0.
// - Offset 0x9C holds codes 0x30..0x33; 0x30 in bits 1-0.
// - Offset 0x9F bits 7-6 hold code 0x3F, vector bits 127:126.
// - Code N sits at vector bits 2N+1 down to 2N.
// - Frame priority is the entry indexed by TOS bits 7:2.
// - All 64 codes decode, each selecting exactly one entry.
module dpmu_top
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [dpmu_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dpmu_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dpmu_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [dpmu_pkg::LOWER_MAP_W-1:0] lower_map,
	input wire dpmu_pkg::dpmu_frame_type frame_in,
	output dpmu_pkg::dpmu_class_type class_out
);

	// Bank layout, one byte per register, lowest code of each group in bits 1-0:
	//   0x94 codes 0x10..0x13, vector bits 39:32
	//   0x95 codes 0x14..0x17, vector bits 47:40
	//   0x96 codes 0x18..0x1B, vector bits 55:48
	//   0x97 codes 0x1C..0x1F, vector bits 63:56
	//   0x98 codes 0x20..0x23, vector bits 71:64
	//   0x99 codes 0x24..0x27, vector bits 79:72
	//   0x9A codes 0x28..0x2B, vector bits 87:80
	//   0x9B codes 0x2C..0x2F, vector bits 95:88
	//   0x9C codes 0x30..0x33, vector bits 103:96
	//   0x9D codes 0x34..0x37, vector bits 111:104
	//   0x9E codes 0x38..0x3B, vector bits 119:112
	//   0x9F codes 0x3C..0x3F, vector bits 127:120
	// Codes 0x00..0x0F belong to the neighbouring bank and arrive on lower_map.
	// Timing: a write at edge k is seen by frames taken at edge k+1 and later;
	// a frame taken at edge k itself still sees the old entry, since both
	// are sampled on the same edge.
	// Reads answer one edge after the strobe and never stall the master.
	// Limitation: an offset outside the bank reads as zero, with no error flag.
	// The lookup is a plain mux over live registers, so there is no shadow
	// copy to keep coherent after a write.

	// Storage bytes, one per register
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_10_13_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_14_17_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_18_1b_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_1c_1f_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_20_23_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_24_27_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_28_2b_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_2c_2f_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_30_33_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_34_37_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_38_3b_r;
	logic [dpmu_pkg::DATA_W-1:0] dscp_map_codes_3c_3f_r;

	// Write selects, one per register
	logic wr_codes_10_13;
	logic wr_codes_14_17;
	logic wr_codes_18_1b;
	logic wr_codes_1c_1f;
	logic wr_codes_20_23;
	logic wr_codes_24_27;
	logic wr_codes_28_2b;
	logic wr_codes_2c_2f;
	logic wr_codes_30_33;
	logic wr_codes_34_37;
	logic wr_codes_38_3b;
	logic wr_codes_3c_3f;

	// Read path, lookup and result
	logic rd_hit;
	logic [dpmu_pkg::DATA_W-1:0] rdata_nxt;
	logic [dpmu_pkg::DATA_W-1:0] rdata_r;
	logic [dpmu_pkg::MAP_W-1:0] map_vec;
	logic [dpmu_pkg::ENTRY_W-1:0] code_entry [dpmu_pkg::MAP_W / dpmu_pkg::ENTRY_W];
	logic [dpmu_pkg::CODE_W-1:0] frame_code;
	logic [dpmu_pkg::ENTRY_W-1:0] prio_nxt;
	logic class_valid_r;
	logic [dpmu_pkg::CODE_W-1:0] class_code_r;
	logic [dpmu_pkg::ENTRY_W-1:0] class_prio_r;

	// Write decode; an exact compare per offset, so any other address writes nothing
	// write selects
	assign wr_codes_10_13 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_10_13);
	assign wr_codes_14_17 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_14_17);
	assign wr_codes_18_1b = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_18_1B);
	assign wr_codes_1c_1f = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_1C_1F);
	assign wr_codes_20_23 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_20_23);
	assign wr_codes_24_27 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_24_27);
	assign wr_codes_28_2b = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_28_2B);
	assign wr_codes_2c_2f = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_2C_2F);
	assign wr_codes_30_33 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_30_33);
	assign wr_codes_34_37 = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_34_37);
	assign wr_codes_38_3b = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_38_3B);
	assign wr_codes_3c_3f = reg_wr && (reg_addr == dpmu_pkg::OFS_CODES_3C_3F);

	// Offsets outside the bank read back as idle
	assign rd_hit = (reg_addr >= dpmu_pkg::OFS_CODES_10_13) && (reg_addr <= dpmu_pkg::OFS_CODES_3C_3F);

	// Offset 0x94, codes 0x10..0x13
	// Vector bits 39:32
	// lowest code in bits 1-0
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_10_13_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_10_13)
			dscp_map_codes_10_13_r <= reg_wdata;
	end

	// Offset 0x95, codes 0x14..0x17
	// Vector bits 47:40
	// four entries per byte
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_14_17_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_14_17)
			dscp_map_codes_14_17_r <= reg_wdata;
	end

	// Offset 0x96, codes 0x18..0x1B
	// Vector bits 55:48
	// four entries per byte
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_18_1b_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_18_1b)
			dscp_map_codes_18_1b_r <= reg_wdata;
	end

	// Offset 0x97, codes 0x1C..0x1F
	// Vector bits 63:56
	// code 0x1F in bits 7-6
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_1c_1f_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_1c_1f)
			dscp_map_codes_1c_1f_r <= reg_wdata;
	end

	// Offset 0x98, codes 0x20..0x23
	// Vector bits 71:64
	// code 0x20 in bits 1-0
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_20_23_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_20_23)
			dscp_map_codes_20_23_r <= reg_wdata;
	end

	// Offset 0x99, codes 0x24..0x27
	// Vector bits 79:72
	// clears to zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_24_27_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_24_27)
			dscp_map_codes_24_27_r <= reg_wdata;
	end

	// Offset 0x9A, codes 0x28..0x2B
	// Vector bits 87:80
	// clears to zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_28_2b_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_28_2b)
			dscp_map_codes_28_2b_r <= reg_wdata;
	end

	// Offset 0x9B, codes 0x2C..0x2F
	// Vector bits 95:88
	// clears to zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_2c_2f_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_2c_2f)
			dscp_map_codes_2c_2f_r <= reg_wdata;
	end

	// Offset 0x9C, codes 0x30..0x33
	// Vector bits 103:96
	// code 0x30 in bits 1-0
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_30_33_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_30_33)
			dscp_map_codes_30_33_r <= reg_wdata;
	end

	// Offset 0x9D, codes 0x34..0x37
	// Vector bits 111:104
	// clears to zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_34_37_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_34_37)
			dscp_map_codes_34_37_r <= reg_wdata;
	end

	// Offset 0x9E, codes 0x38..0x3B
	// Vector bits 119:112
	// code 0x3B at 119:118
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_38_3b_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_38_3b)
			dscp_map_codes_38_3b_r <= reg_wdata;
	end

	// Offset 0x9F, codes 0x3C..0x3F
	// Vector bits 127:120
	// code 0x3F in bits 7-6
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dscp_map_codes_3c_3f_r <= dpmu_pkg::REG_RESET;
		else if (wr_codes_3c_3f)
			dscp_map_codes_3c_3f_r <= reg_wdata;
	end

	// Read select; an unmapped offset gives the idle value rather than a stale byte
	// read back
	always_comb
	begin
		rdata_nxt = dpmu_pkg::RDATA_IDLE;
		case (reg_addr)
			dpmu_pkg::OFS_CODES_10_13: rdata_nxt = dscp_map_codes_10_13_r;
			dpmu_pkg::OFS_CODES_14_17: rdata_nxt = dscp_map_codes_14_17_r;
			dpmu_pkg::OFS_CODES_18_1B: rdata_nxt = dscp_map_codes_18_1b_r;
			dpmu_pkg::OFS_CODES_1C_1F: rdata_nxt = dscp_map_codes_1c_1f_r;
			dpmu_pkg::OFS_CODES_20_23: rdata_nxt = dscp_map_codes_20_23_r;
			dpmu_pkg::OFS_CODES_24_27: rdata_nxt = dscp_map_codes_24_27_r;
			dpmu_pkg::OFS_CODES_28_2B: rdata_nxt = dscp_map_codes_28_2b_r;
			dpmu_pkg::OFS_CODES_2C_2F: rdata_nxt = dscp_map_codes_2c_2f_r;
			dpmu_pkg::OFS_CODES_30_33: rdata_nxt = dscp_map_codes_30_33_r;
			dpmu_pkg::OFS_CODES_34_37: rdata_nxt = dscp_map_codes_34_37_r;
			dpmu_pkg::OFS_CODES_38_3B: rdata_nxt = dscp_map_codes_38_3b_r;
			dpmu_pkg::OFS_CODES_3C_3F: rdata_nxt = dscp_map_codes_3c_3f_r;
			default: rdata_nxt = dpmu_pkg::RDATA_IDLE;
		endcase
	end

	// Read data stands only in the cycle after the strobe, then drops back to idle
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rdata_r <= dpmu_pkg::RDATA_IDLE;
		else if (reg_rd && rd_hit)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= dpmu_pkg::RDATA_IDLE;
	end

	// Full 128-bit vector: lower codes come from the neighbouring bank, upper from here
	// four entries per byte
	assign map_vec = {
		dscp_map_codes_3c_3f_r,
		dscp_map_codes_38_3b_r,
		dscp_map_codes_34_37_r,
		dscp_map_codes_30_33_r,
		dscp_map_codes_2c_2f_r,
		dscp_map_codes_28_2b_r,
		dscp_map_codes_24_27_r,
		dscp_map_codes_20_23_r,
		dscp_map_codes_1c_1f_r,
		dscp_map_codes_18_1b_r,
		dscp_map_codes_14_17_r,
		dscp_map_codes_10_13_r,
		lower_map
	};

	// Per-code view of the vector; the entry index equals the code, so all 64 decode
	// one entry per code
	genvar gc;
	generate
		for (gc = 0; gc < dpmu_pkg::MAP_W / dpmu_pkg::ENTRY_W; gc++)
		begin : g_entry
			assign code_entry[gc] = map_vec[gc * dpmu_pkg::ENTRY_W +: dpmu_pkg::ENTRY_W];
		end
	endgenerate

	assign frame_code = frame_in.tos[dpmu_pkg::TOS_CODE_LSB +: dpmu_pkg::CODE_W];

	// Plain mux over the live registers, so no shadow copy can go stale after a write
	// mux over registers
	assign prio_nxt = code_entry[frame_code];

	// Valid follows the frame strobe by exactly one edge
	// frame strobe to result
	always_ff @(posedge core_clk)
	begin
		if (srst)
			class_valid_r <= '0;
		else
			class_valid_r <= frame_in.valid;
	end

	// Code travels with the result so the classifier can tell which entry it got
	always_ff @(posedge core_clk)
	begin
		if (srst)
			class_code_r <= '0;
		else
			class_code_r <= frame_code;
	end

	// Priority is taken every edge; it only means something while valid is high
	// top entry reaches the output
	always_ff @(posedge core_clk)
	begin
		if (srst)
			class_prio_r <= dpmu_pkg::PRIO_RESET;
		else
			class_prio_r <= prio_nxt;
	end

	// Outputs come straight from the flip-flops above
	assign reg_rdata = rdata_r;
	assign class_out = '{valid: class_valid_r, code: class_code_r, prio: class_prio_r};

endmodule // dpmu_top

// >>> verilog/dpmu_pkg.sv
// Constants and carrier types for the upper DiffServ priority map
package dpmu_pkg;

	// Register port widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// Map geometry
	localparam int unsigned ENTRY_W = 2;
	localparam int unsigned CODE_W = 6;
	localparam int unsigned ENTRIES_PER_REG = 4;
	localparam int unsigned NUM_REGS = 12;
	localparam int unsigned MAP_W = 128;
	localparam int unsigned LOWER_MAP_W = 32;
	localparam int unsigned TOS_CODE_LSB = 2;

	// Code range held by this bank
	localparam logic [5:0] FIRST_CODE = 6'h10;
	localparam logic [5:0] LAST_CODE = 6'h3F;

	// Register offsets; the bank is contiguous from the first one
	localparam logic [7:0] OFS_CODES_10_13 = 8'h94;
	localparam logic [7:0] OFS_CODES_14_17 = 8'h95;
	localparam logic [7:0] OFS_CODES_18_1B = 8'h96;
	localparam logic [7:0] OFS_CODES_1C_1F = 8'h97;
	localparam logic [7:0] OFS_CODES_20_23 = 8'h98;
	localparam logic [7:0] OFS_CODES_24_27 = 8'h99;
	localparam logic [7:0] OFS_CODES_28_2B = 8'h9A;
	localparam logic [7:0] OFS_CODES_2C_2F = 8'h9B;
	localparam logic [7:0] OFS_CODES_30_33 = 8'h9C;
	localparam logic [7:0] OFS_CODES_34_37 = 8'h9D;
	localparam logic [7:0] OFS_CODES_38_3B = 8'h9E;
	localparam logic [7:0] OFS_CODES_3C_3F = 8'h9F;
	localparam logic [7:0] REG_COUNT = 8'h0C;

	// Reset and idle values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	localparam logic [1:0] PRIO_RESET = 2'h0;

	// Frame arriving from the parser
	typedef struct packed {
		logic valid;
		logic [7:0] tos;
	} dpmu_frame_type;

	// Classification result toward the queue classifier
	typedef struct packed {
		logic valid;
		logic [5:0] code;
		logic [1:0] prio;
	} dpmu_class_type;

endpackage

// >>> dv/dpmu_checker.sv
// Port checker for the upper priority map
`timescale 1ns/1ps
module dpmu_checker
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [31:0] lower_map,
	input wire dpmu_pkg::dpmu_frame_type frame_in,
	input wire dpmu_pkg::dpmu_class_type class_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_vld; 1 |=> class_out.valid == $past(frame_in.valid); endproperty
	a_vld: assert property (p_vld) else $error("valid");
	property p_code; frame_in.valid |=> class_out.code == $past(frame_in.tos[7:2]); endproperty
	a_code: assert property (p_code) else $error("code");
	property p_rdz; !(reg_rd && reg_addr inside {[8'h94:8'h9F]}) |=> reg_rdata == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("rdata");
	property p_wr;
		reg_wr && reg_addr inside {[8'h94:8'h9F]} ##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_wr: assert property (p_wr) else $error("readback");
	property p_1f; reg_wr && reg_addr == 8'h97 ##1 frame_in.tos[7:2] == 6'h1F |=> class_out.prio == $past(reg_wdata[7:6], 2); endproperty
	a_1f: assert property (p_1f) else $error("1f");
	property p_20; reg_wr && reg_addr == 8'h98 ##1 frame_in.tos[7:2] == 6'h20 |=> class_out.prio == $past(reg_wdata[1:0], 2); endproperty
	a_20: assert property (p_20) else $error("20");
	property p_30; reg_wr && reg_addr == 8'h9C ##1 frame_in.tos[7:2] == 6'h30 |=> class_out.prio == $past(reg_wdata[1:0], 2); endproperty
	a_30: assert property (p_30) else $error("30");
	property p_3f; reg_wr && reg_addr == 8'h9F ##1 frame_in.tos[7:2] == 6'h3F |=> class_out.prio == $past(reg_wdata[7:6], 2); endproperty
	a_3f: assert property (p_3f) else $error("3f");
	c_wr: cover property (reg_wr ##1 reg_rd);
	c_top: cover property (frame_in.valid && frame_in.tos[7:2] == 6'h3F);
	c_bad: cover property (reg_rd && reg_addr > 8'h9F);
endmodule // dpmu_checker
bind dpmu_top dpmu_checker u_chk (.*);

// >>> dv/dpmu_tb_top.sv
// Random and corner bench for the upper priority map
`timescale 1ns/1ps
`define CHK(n,e,a) begin compares++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module dpmu_tb_top;
	logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, er = 0;
	logic [31:0] lower_map = 0, s = 32'h1405EC05;
	logic [95:0] m = 0;
	logic [127:0] v;
	logic [8:0] ec = 0;
	dpmu_pkg::dpmu_frame_type frame_in = 0;
	dpmu_pkg::dpmu_class_type class_out;
	int num_errors = 0, compares = 0, i, n = 0;
	dpmu_top dut (.*);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (++n > 9000) begin num_errors++; report_and_stop; end
	function logic [31:0] xs(); s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s; endfunction
	// Expected read data and class result, from the model bytes m and vector v
	function logic [7:0] exp_rd(logic [1:0] op, logic [7:0] a);
		return (op == 2 && a inside {[8'h94:8'h9F]}) ? m[(a - 8'h94) * 8 +: 8] : 8'h00;
	endfunction
	function logic [8:0] exp_class(logic f, logic [7:0] t);
		return {f, t[7:2], v[t[7:2] * 2 +: 2]};
	endfunction
	// One bus and frame cycle; checks the answers to the previous cycle
	task cyc(logic [1:0] op, logic [7:0] a, d, t, logic f);
		@(posedge core_clk);
		reg_wr <= op == 1; reg_rd <= op == 2; reg_addr <= a; reg_wdata <= d;
		frame_in <= {f, t}; lower_map <= s;
		#1;
		`CHK("rdata", er, reg_rdata)
		`CHK("class", ec, class_out)
		v = {m, s};
		er = exp_rd(op, a);
		ec = exp_class(f, t);
		if (op == 1 && a inside {[8'h94:8'h9F]}) m[(a - 8'h94) * 8 +: 8] = d;
	endtask
	task report_and_stop;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 0;
		for (i = 0; i < 16; i++) cyc(2, 8'h92 + i, 0, 0, 0);
		cyc(1, 8'h97, 8'hC0, 0, 0);
		cyc(2, 8'h97, 0, 8'h7C, 1);
		cyc(1, 8'h98, 8'h03, 0, 0);
		cyc(0, 0, 0, 8'h80, 1);
		cyc(1, 8'h9C, 8'h02, 0, 0);
		cyc(0, 0, 0, 8'hC0, 1);
		cyc(1, 8'h9F, 8'hC0, 0, 0);
		cyc(0, 0, 0, 8'hFC, 1);
		repeat (3000) begin s = xs(); cyc(s[1:0], 8'h92 + s[5:2], s[15:8], s[31:24], s[16]); end
		cyc(0, 0, 0, 0, 0);
		// Mid-run reset: every byte must read zero again afterwards
		@(posedge core_clk) srst <= 1;
		@(posedge core_clk) srst <= 0;
		m = 0;
		v = {m, s};
		er = 8'h00;
		ec = exp_class(0, 0);
		for (i = 0; i < 16; i++) cyc(2, 8'h92 + i, 0, 0, 0);
		cyc(0, 0, 0, 0, 0);
		report_and_stop;
	end
endmodule // dpmu_tb_top
